// ===== verilog/nabg_top.sv
/*
  Memory write unlock and bus target address forming for a managed
  power converter. Commands arrive already decoded from the management
  bus as code, direction and data; one answer follows each command.
  Assumes the strap inputs come from an analog decoder on another
  timing, so they are synchronised here before use.
*/
`timescale 1ns/1ns
`include "nabg_map.svh"
module nabg_top
  import nabg_pkg::*;
#(
  parameter logic [15:0] UNLOCK_KEY = `NABG_KEY_DEFAULT,
  parameter int ADDR_W = 7,
  parameter int OFFSET_W = 4
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_valid,
  output logic rsp_ack,
  output logic [15:0] rsp_rdata,
  input wire logic [OFFSET_W-1:0] addr_strap_offset,
  input wire logic voltage_select_strap_pin_floating,
  output logic [ADDR_W-1:0] bus_target_address,
  output logic bus_address_valid,
  output logic nvm_write_enable
);

  // The address split is fixed by the base field and offset width
  initial begin
    if (ADDR_W != 7 || OFFSET_W != 4) begin
      $error("nabg_top: address must be 7 bits with a 4-bit offset");
    end
  end

  // Synchroniser stages for the strap inputs
  logic [OFFSET_W-1:0] off_s1_r;
  logic [OFFSET_W-1:0] off_s2_r;
  logic flt_s1_r;
  logic flt_s2_r;

  // Strap capture
  nabg_state_t state_r;
  nabg_state_t state_nxt;
  logic [1:0] settle_r;
  logic [1:0] settle_nxt;
  logic [OFFSET_W-1:0] off_hold_r;
  logic [OFFSET_W-1:0] off_hold_nxt;
  logic flt_hold_r;
  logic flt_hold_nxt;

  // Registers and unlock state
  logic [7:0] base_pri_r;
  logic [7:0] base_pri_nxt;
  logic [7:0] base_alt_r;
  logic [7:0] base_alt_nxt;
  logic unlock_r;
  logic unlock_nxt;

  // Answer and address outputs
  logic rsp_valid_r;
  logic rsp_valid_nxt;
  logic rsp_ack_r;
  logic rsp_ack_nxt;
  logic [15:0] rsp_rdata_r;
  logic [15:0] rsp_rdata_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic addr_ok_r;
  logic addr_ok_nxt;

  logic wr_key;
  logic wr_pri;
  logic wr_alt;
  logic [7:0] base_sel;

  // Two flops before any logic reads the strap levels
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      off_s1_r <= '0;
      off_s2_r <= '0;
      flt_s1_r <= 1'b0;
      flt_s2_r <= 1'b0;
    end else begin
      off_s1_r <= addr_strap_offset;
      off_s2_r <= off_s1_r;
      flt_s1_r <= voltage_select_strap_pin_floating;
      flt_s2_r <= flt_s1_r;
    end
  end

  // Capture straps once the synchroniser has flushed its reset value;
  // holding them keeps the address steady if the analog decode wanders
  always_comb begin
    state_nxt = state_r;
    settle_nxt = settle_r;
    off_hold_nxt = off_hold_r;
    flt_hold_nxt = flt_hold_r;
    case (state_r)
      NABG_ST_SETTLE: begin
        if (settle_r == `NABG_SETTLE_CYC) begin
          off_hold_nxt = off_s2_r;
          flt_hold_nxt = flt_s2_r;
          state_nxt = NABG_ST_RUN;
        end else begin
          settle_nxt = settle_r + 2'h1;
        end
      end
      NABG_ST_RUN: begin
        state_nxt = NABG_ST_RUN; // Held until the next reset
      end
      default: begin
        state_nxt = NABG_ST_SETTLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_r <= NABG_ST_SETTLE;
      settle_r <= 2'h0;
      off_hold_r <= '0;
      flt_hold_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      settle_r <= settle_nxt;
      off_hold_r <= off_hold_nxt;
      flt_hold_r <= flt_hold_nxt;
    end
  end

  // Write decode
  assign wr_key = cmd_valid && cmd_write && (cmd_code == `NABG_CMD_UNLOCK_KEY);
  assign wr_pri = cmd_valid && cmd_write && (cmd_code == `NABG_CMD_BASE_PRI);
  assign wr_alt = cmd_valid && cmd_write && (cmd_code == `NABG_CMD_BASE_ALT);

  // Base registers and unlock flag; a wrong key relocks at once
  always_comb begin
    base_pri_nxt = base_pri_r;
    base_alt_nxt = base_alt_r;
    unlock_nxt = unlock_r;
    if (wr_pri) begin
      base_pri_nxt = cmd_wdata[7:0];
    end
    if (wr_alt) begin
      base_alt_nxt = cmd_wdata[7:0];
    end
    if (wr_key) begin
      unlock_nxt = (cmd_wdata == UNLOCK_KEY);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      base_pri_r <= `NABG_BASE_PRI_RST;
      base_alt_r <= `NABG_BASE_ALT_RST;
      unlock_r <= 1'b0; // Power-up starts locked
    end else begin
      base_pri_r <= base_pri_nxt;
      base_alt_r <= base_alt_nxt;
      unlock_r <= unlock_nxt;
    end
  end

  // Floating strap picks the alternate base, grounded the primary
  assign base_sel = flt_hold_r ? base_alt_r : base_pri_r;

  // One answer per command; the key is write-only and reads are refused
  always_comb begin
    rsp_valid_nxt = cmd_valid;
    rsp_ack_nxt = 1'b0;
    rsp_rdata_nxt = 16'h0000;
    if (cmd_valid) begin
      case (cmd_code)
        `NABG_CMD_UNLOCK_KEY: begin
          rsp_ack_nxt = cmd_write;
        end
        `NABG_CMD_BASE_PRI: begin
          rsp_ack_nxt = 1'b1;
          if (!cmd_write) begin
            rsp_rdata_nxt = {`NABG_ZERO_BYTE, base_pri_r};
          end
        end
        `NABG_CMD_BASE_ALT: begin
          rsp_ack_nxt = 1'b1;
          if (!cmd_write) begin
            rsp_rdata_nxt = {`NABG_ZERO_BYTE, base_alt_r};
          end
        end
        default: begin
          rsp_ack_nxt = 1'b0;
        end
      endcase
    end
  end

  // Address is formed from the selected base and the held offset
  always_comb begin
    addr_nxt = {base_sel[`NABG_BASE_HI:`NABG_BASE_LO], off_hold_r};
    addr_ok_nxt = (state_r == NABG_ST_RUN);
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rsp_valid_r <= 1'b0;
      rsp_ack_r <= 1'b0;
      rsp_rdata_r <= 16'h0000;
      addr_r <= '0;
      addr_ok_r <= 1'b0;
    end else begin
      rsp_valid_r <= rsp_valid_nxt;
      rsp_ack_r <= rsp_ack_nxt;
      rsp_rdata_r <= rsp_rdata_nxt;
      addr_r <= addr_nxt;
      addr_ok_r <= addr_ok_nxt;
    end
  end

  assign rsp_valid = rsp_valid_r;
  assign rsp_ack = rsp_ack_r;
  assign rsp_rdata = rsp_rdata_r;
  assign bus_target_address = addr_r;
  assign bus_address_valid = addr_ok_r;
  assign nvm_write_enable = unlock_r; // Store-all is gated by this

  // Checks on the block's own behaviour
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  a_key_opens: assert property (
    wr_key && cmd_wdata == UNLOCK_KEY |=> nvm_write_enable)
    else $error("correct key did not unlock");

  a_bad_key_locks: assert property (
    wr_key && cmd_wdata != UNLOCK_KEY |=> !nvm_write_enable)
    else $error("wrong key left memory unlocked");

  a_lock_after_reset: assert property (
    $rose(rst_b) |-> !nvm_write_enable)
    else $error("memory unlocked straight after reset");

  a_unlock_cause: assert property (
    $rose(nvm_write_enable) |-> $past(wr_key) && $past(cmd_wdata) == UNLOCK_KEY)
    else $error("unlock without the key");

  a_addr_form: assert property (
    bus_address_valid |=> bus_target_address ==
      {$past(base_sel[`NABG_BASE_HI:`NABG_BASE_LO]), $past(off_hold_r)})
    else $error("target address not base plus offset");

  a_addr_upper: assert property (
    bus_address_valid && !flt_hold_r && $stable(base_pri_r) |->
      bus_target_address[6:4] == base_pri_r[6:4])
    else $error("grounded strap did not use primary base");

  a_addr_alt: assert property (
    bus_address_valid && flt_hold_r && $stable(base_alt_r) |->
      bus_target_address[6:4] == base_alt_r[6:4])
    else $error("floating strap did not use alternate base");

  a_offset_low: assert property (
    bus_address_valid |-> bus_target_address[3:0] == off_hold_r)
    else $error("low address bits differ from held offset");

  a_base_reset: assert property (
    $rose(rst_b) |-> base_pri_r == `NABG_BASE_PRI_RST &&
      base_alt_r == `NABG_BASE_ALT_RST)
    else $error("base registers wrong after reset");

  a_base_readback: assert property (
    wr_pri ##1 !wr_pri ##1 (cmd_valid && !cmd_write && cmd_code == `NABG_CMD_BASE_PRI) |=>
      rsp_rdata == {8'h00, $past(cmd_wdata[7:0], 3)})
    else $error("primary base did not read back");

  a_strap_held: assert property (
    state_r == NABG_ST_RUN |=> $stable(off_hold_r) && $stable(flt_hold_r))
    else $error("strap capture changed after sampling");

  a_addr_ready_time: assert property (
    $rose(rst_b) |-> ##5 bus_address_valid)
    else $error("address not valid five cycles after reset");

  a_one_answer: assert property (
    cmd_valid |=> rsp_valid ##1 (!rsp_valid || $past(cmd_valid)))
    else $error("command did not get exactly one answer");

  c_unlock: cover property (wr_key && cmd_wdata == UNLOCK_KEY ##1 nvm_write_enable);
  c_relock: cover property (nvm_write_enable ##1 wr_key && cmd_wdata != UNLOCK_KEY);
  c_alt_used: cover property (bus_address_valid && flt_hold_r);
  c_refused: cover property (rsp_valid && !rsp_ack);

endmodule : nabg_top

// ===== verilog/nabg_map.svh
/*
  Constants for the memory-unlock and bus-address block: command codes,
  reset values, field positions and strap settle time.
  Assumes inclusion by the block and its bench only; definitions only.
*/
// What this block does
// - Correct 16-bit key written at command DBh opens memory write access.
// - Any other value written at DBh closes memory write access.
// - Write access is closed after every power-up reset.
// - Key that opens access defaults to 1234h.
// - Bus target address is seven bits: register base plus strap offset.
// - Upper three address bits are bits 6 to 4 of the chosen base.
// - Lower four address bits are the decoded strap-resistor offset.
// - Grounded voltage-select strap chooses the primary base at D7h.
// - Floating voltage-select strap chooses the alternate base at E2h.
// - Bases reset to 10h and 50h, both readable and writable.
`ifndef NABG_MAP_SVH
`define NABG_MAP_SVH
`define NABG_CMD_UNLOCK_KEY 8'hDB
`define NABG_CMD_BASE_PRI 8'hD7
`define NABG_CMD_BASE_ALT 8'hE2
`define NABG_KEY_DEFAULT 16'h1234
`define NABG_BASE_PRI_RST 8'h10
`define NABG_BASE_ALT_RST 8'h50
`define NABG_BASE_HI 6
`define NABG_BASE_LO 4
`define NABG_SETTLE_CYC 2'h3
`define NABG_ZERO_BYTE 8'h00
`endif

// ===== verilog/nabg_pkg.sv
/*
  Types of the memory-unlock and bus-address block.
  Assumes the map header supplies all numeric constants.
*/
package nabg_pkg;
  // Strap capture sequence after reset
  typedef enum logic [0:0] {
    NABG_ST_SETTLE,
    NABG_ST_RUN
  } nabg_state_t;
endpackage : nabg_pkg

// ===== tb/nabg_host.sv
/*
  Host model for the memory-unlock and bus-address block: issues one
  decoded command at a time and collects its answer.
  Assumes a free-running clock and a bench that calls cmd after reset.
*/
`timescale 1ns/1ns
module nabg_host (
  input wire logic clock,
  input wire logic rsp_valid,
  input wire logic rsp_ack,
  input wire logic [15:0] rsp_rdata,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata
);
  // Idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // One command, answer read mid-cycle after the taking edge
  // Bench sends key writes before any store request
  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d,
                     output logic v, output logic a, output logic [15:0] r);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_code <= c;
    cmd_wdata <= d;
    @(posedge clock);
    cmd_valid <= 1'b0;
    // Released lines show inverted data so stale values never match
    cmd_write <= ~w;
    cmd_code <= ~c;
    cmd_wdata <= ~d;
    @(negedge clock);
    v = rsp_valid;
    a = rsp_ack;
    r = rsp_rdata;
  endtask : cmd
endmodule : nabg_host

// ===== tb/test_nabg_top.sv
/*
  Self-checking bench for the memory-unlock and bus-address block.
  Assumes the host model drives the command port; straps come from here.
*/
`timescale 1ns/1ns
`include "nabg_map.svh"
module test_nabg_top;
  logic clock, rst_b, cmd_valid, cmd_write, rsp_valid, rsp_ack;
  logic bus_address_valid, nvm_write_enable, flt, cap_flt, v, a, lk;
  logic [7:0] cmd_code, bp, ba;
  logic [15:0] cmd_wdata, rsp_rdata, r, k;
  logic [3:0] off, cap_off;
  logic [6:0] bus_target_address;
  logic [31:0] seed;
  int n_errors, n_checks;

  nabg_top nabg_top_inst (.clock(clock), .rst_b(rst_b), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_ack(rsp_ack), .rsp_rdata(rsp_rdata),
    .addr_strap_offset(off), .voltage_select_strap_pin_floating(flt),
    .bus_target_address(bus_target_address), .bus_address_valid(bus_address_valid),
    .nvm_write_enable(nvm_write_enable));
  nabg_host nabg_host_inst (.clock(clock), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack),
    .rsp_rdata(rsp_rdata), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));

  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Expected address from the selected base and captured offset
  function automatic logic [15:0] exp_addr();
    logic [7:0] b;
    b = cap_flt ? ba : bp;
    return {9'h000, b[6:4], cap_off};
  endfunction : exp_addr

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Command with a check that the answer pulse came
  task automatic xact(input logic w, input logic [7:0] c, input logic [15:0] d);
    nabg_host_inst.cmd(w, c, d, v, a, r);
    chk({15'h0000, v}, 16'h0001);
  endtask : xact

  task automatic results;
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  // Straps set with reset and held through capture
  task automatic do_reset(input logic f, input logic [3:0] o);
    int i;
    @(posedge clock);
    rst_b <= 1'b0;
    flt <= f;
    off <= o;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    cap_flt = f;
    cap_off = o;
    bp = `NABG_BASE_PRI_RST;
    ba = `NABG_BASE_ALT_RST;
    for (i = 0; i < 20 && bus_address_valid !== 1'b1; i++) @(negedge clock);
    if (bus_address_valid !== 1'b1) begin
      n_errors++;
      results();
    end
  endtask : do_reset

  initial begin
    seed = 32'hB3D317A6;
    rst_b = 1'b0;
    flt = 1'b0;
    off = 4'h0;
    n_errors = 0;
    n_checks = 0;
    // Passes 0 and 1 give addresses 17h and 5Bh; later passes use a random offset
    for (int p = 0; p < 4; p++) begin
      k = 16'(xs());
      do_reset(p[0], p == 0 ? 4'h7 : p == 1 ? 4'hB : k[3:0]);
      chk({15'h0000, nvm_write_enable}, 16'h0000);
      chk({9'h000, bus_target_address}, exp_addr());
      xact(1'b0, `NABG_CMD_BASE_PRI, 16'h0000);
      chk(r, 16'h0010);
      xact(1'b0, `NABG_CMD_BASE_ALT, 16'h0000);
      chk(r, 16'h0050);
      xact(1'b0, `NABG_CMD_UNLOCK_KEY, 16'h0000);
      chk({15'h0000, a}, 16'h0000);
      xact(1'b1, 8'hA5, 16'h1234);
      chk({15'h0000, a}, 16'h0000);
      chk({15'h0000, nvm_write_enable}, 16'h0000);
      lk = 1'b0;
      for (int j = 0; j < 12; j++) begin
        k = 16'(xs());
        // Key: the right one, or a wrong one
        if (k[9]) k = 16'h1234;
        else if (k == 16'h1234) k = 16'h1235;
        lk = (k == 16'h1234);
        xact(1'b1, `NABG_CMD_UNLOCK_KEY, k);
        chk({15'h0000, a}, 16'h0001);
        chk({15'h0000, nvm_write_enable}, {15'h0000, lk});
        k = 16'(xs());
        if (k[12]) bp = k[7:0];
        else ba = k[7:0];
        xact(1'b1, k[12] ? `NABG_CMD_BASE_PRI : `NABG_CMD_BASE_ALT, k);
        // Read straight back, one idle cycle after the write
        xact(1'b0, k[12] ? `NABG_CMD_BASE_PRI : `NABG_CMD_BASE_ALT, 16'h0000);
        chk(r, {8'h00, k[7:0]});
        // Straps moved after capture must not show
        @(posedge clock);
        off <= k[11:8];
        flt <= k[13];
        repeat (2) @(negedge clock);
        chk({9'h000, bus_target_address}, exp_addr());
        xact(1'b0, k[12] ? `NABG_CMD_BASE_PRI : `NABG_CMD_BASE_ALT, 16'h0000);
        chk(r, {8'h00, k[7:0]});
      end
      // Leave unlocked so the next reset must lock it
      xact(1'b1, `NABG_CMD_UNLOCK_KEY, 16'h1234);
      chk({15'h0000, nvm_write_enable}, 16'h0001);
    end
    results();
  end
endmodule : test_nabg_top
